/* pefg_host_model.sv */
// External host that drives the slave-port strobes and the lower data port.
// Assumes strobes are active low and idle high; bit 2 select, bit 1 write, bit 0 read.
`timescale 1ns/1ps
`default_nettype none
module pefg_host (
   input  wire logic       clk_sys,
   output var  logic [2:0] ctl_n,
   output var  logic [7:0] data
);
   // ****************
   // Strobe cycles
   // ****************
   initial begin
      ctl_n = 3'b111;
      data = 8'h00;
   end
   task automatic xfer(input logic rd, input logic sel, input logic [7:0] d);
      @(posedge clk_sys);
      ctl_n[2] <= ~sel;
      data <= rd ? ~data : d;
      repeat (4) @(posedge clk_sys);
      if (rd) ctl_n[0] <= 1'b0;
      else ctl_n[1] <= 1'b0;
      repeat (6) @(posedge clk_sys);
      ctl_n[1:0] <= 2'b11;
      repeat (6) @(posedge clk_sys);
      ctl_n[2] <= 1'b1;
      // A released bus shows the inverse so stale data never passes.
      data <= ~data;
   endtask : xfer
endmodule : pefg_host
`default_nettype wire

/* pefg_latch.sv */
// Output latch bank that survives warm resets and clears only on power-on reset.
// Assumes por is an asynchronous active-high power-on/brown-out reset.
`timescale 1ns/1ps
`default_nettype none
module pefg_latch
   import pefg_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       por,
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_data,
   output var  logic [7:0] lat_q
);
   // Warm reset does not reach this bank, so the latch holds its value.
   always_ff @(posedge clk_sys or posedge por) begin
      if (por) begin
         lat_q <= PEFG_LAT_POR;
      end else if (wr_en) begin
         lat_q <= wr_data;
      end
   end
endmodule : pefg_latch
`default_nettype wire

/* pefg_pkg.sv */
// Package for the port E / port F I/O block: register map, field layout, reset values.
// Assumes a 32-bit classic Wishbone register bus with word-aligned registers.
package pefg_pkg;

   localparam logic [7:0] PEFG_ADDR_E_DIR   = 8'h00;
   localparam logic [7:0] PEFG_ADDR_E_PINS  = 8'h04;
   localparam logic [7:0] PEFG_ADDR_E_LAT   = 8'h08;
   localparam logic [7:0] PEFG_ADDR_BUSCTL  = 8'h0C;
   localparam logic [7:0] PEFG_ADDR_SPCTL   = 8'h10;
   localparam logic [7:0] PEFG_ADDR_F_DIR   = 8'h14;
   localparam logic [7:0] PEFG_ADDR_F_PINS  = 8'h18;
   localparam logic [7:0] PEFG_ADDR_F_LAT   = 8'h1C;
   localparam logic [7:0] PEFG_ADDR_CFG     = 8'h20;
   localparam logic [7:0] PEFG_ADDR_LDP     = 8'h24;

   localparam logic [7:0] PEFG_DIR_RST      = 8'hFF;
   localparam logic [7:0] PEFG_SPCTL_RST    = 8'h00;
   localparam logic [7:0] PEFG_BUSCTL_RST   = 8'h00;
   localparam logic [7:0] PEFG_LAT_POR      = 8'h00;
   localparam logic [7:0] PEFG_BUSCTL_MASK  = 8'hB3;
   localparam logic [7:0] PEFG_SPCTL_MASK   = 8'hF0;
   localparam logic [7:0] PEFG_F_PIN_PORMSK = 8'h80;

   localparam int PEFG_BUSCTL_EXTERNAL_BUS_DISABLE_BIT = 7;
   localparam int PEFG_SP_IBF_BIT       = 7;
   localparam int PEFG_SP_OBF_BIT       = 6;
   localparam int PEFG_SP_INPUT_BUFFER_OVERFLOW_BIT      = 5;
   localparam int PEFG_SP_MODE_BIT      = 4;
   localparam int PEFG_CFG_PWMMX_BIT    = 0;
   localparam int PEFG_CFG_CH2MX_BIT    = 1;
   localparam int PEFG_PIN_RD           = 0;
   localparam int PEFG_PIN_WR           = 1;
   localparam int PEFG_PIN_CS           = 2;
   localparam int PEFG_PIN_CH2          = 7;

   typedef enum logic [2:0] {
      PEFG_MODE_IO  = 3'b001,
      PEFG_MODE_BUS = 3'b010,
      PEFG_MODE_SP  = 3'b100
   } pefg_mode_e;

   typedef struct packed {
      logic [7:0] e_dir;
      logic [7:0] e_lat;
      logic [7:0] f_dir;
      logic [7:0] f_lat;
      logic [7:0] busctl;
      logic [7:0] spctl;
      logic [7:0] ldp_in;
      logic [1:0] cfg;
      logic       f_por_mask;
      logic       ack;
      logic [31:0] dat;
   } pefg_state_s;

   typedef struct packed {
      logic       cyc;
      logic       stb;
      logic       we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } pefg_wb_req_s;

endpackage : pefg_pkg

/* pefg_port_ef.sv */
// Port E / port F GPIO block with slave-port strobe decode.
// Assumes a classic Wishbone master on clk_sys and external pins behind three-signal pads.
`timescale 1ns/1ps
`default_nettype none
module pefg_port_ef
   import pefg_pkg::*;
#(
   parameter bit HAS_EXT_BUS = 1'b1
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        por,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   input  wire logic        mcu_mode,
   input  wire logic [7:0]  ext_addr_hi,
   input  wire logic [3:0]  pwm_out,
   input  wire logic        ch2_out,
   input  wire logic        ch2_oe,
   output var  logic        ch2_in,
   output var  logic [3:0]  pwm_alt_out,
   output var  logic        ch2_on_alt,
   input  wire logic [7:0]  lower_data_port_out,
   output var  logic [7:0]  lower_data_port_in,
   output var  logic        sp_read_active,
   output var  logic        sp_write_pulse,
   output var  logic [7:0]  port_e_in_schmitt,
   output var  logic        port_e_ttl_sel,
   input  wire logic [7:0]  port_e_i,
   output var  logic [7:0]  port_e_o,
   output var  logic [7:0]  port_e_oe,
   input  wire logic [7:0]  port_f_i,
   output var  logic [7:0]  port_f_o,
   output var  logic [7:0]  port_f_oe
);
   // ***************************************************************
   // State and pin synchronisers
   // ***************************************************************
   pefg_state_s st_reg;
   pefg_state_s st_next;
   pefg_wb_req_s req;
   pefg_mode_e   mode;
   logic [7:0]   e_sync;
   logic [7:0]   f_sync;
   logic [7:0]   e_lat_q;
   logic [7:0]   f_lat_q;
   logic         e_lat_wr;
   logic         f_lat_wr;
   logic         acc;
   logic         wr_acc;
   logic         sp_active;
   logic         rd_n_prev_reg;
   logic         wr_n_prev_reg;
   logic         sp_wr_edge;
   logic         sp_rd_edge;

   assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                  adr: wb_adr_i, dat: wb_dat_i};

   pefg_sync #(.WIDTH(8)) u_sync_e (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .async_in (port_e_i),
      .sync_out (e_sync)
   );

   pefg_sync #(.WIDTH(8)) u_sync_f (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .async_in (port_f_i),
      .sync_out (f_sync)
   );

   pefg_latch u_lat_e (
      .clk_sys (clk_sys),
      .por     (por),
      .wr_en   (e_lat_wr),
      .wr_data (req.dat[7:0]),
      .lat_q   (e_lat_q)
   );

   pefg_latch u_lat_f (
      .clk_sys (clk_sys),
      .por     (por),
      .wr_en   (f_lat_wr),
      .wr_data (req.dat[7:0]),
      .lat_q   (f_lat_q)
   );

   // ***************************************************************
   // Mode selection
   // ***************************************************************
   logic bus_ctl_eff;
   logic [7:0] busctl_rd;
   assign busctl_rd   = HAS_EXT_BUS ? st_reg.busctl : 8'h00;
   assign bus_ctl_eff = HAS_EXT_BUS && !mcu_mode
                        && !st_reg.busctl[PEFG_BUSCTL_EXTERNAL_BUS_DISABLE_BIT];
   // Slave mode is only honoured in microcontroller mode, or in any mode when HAS_EXT_BUS is clear.
   assign sp_active = st_reg.spctl[PEFG_SP_MODE_BIT] && (mcu_mode || !HAS_EXT_BUS);

   always_comb begin
      if (bus_ctl_eff) begin
         mode = PEFG_MODE_BUS;
      end else if (sp_active) begin
         mode = PEFG_MODE_SP;
      end else begin
         mode = PEFG_MODE_IO;
      end
   end

   // TTL thresholds in bus and slave modes, Schmitt otherwise.
   assign port_e_ttl_sel    = (mode != PEFG_MODE_IO);
   assign port_e_in_schmitt = e_sync;

   // ***************************************************************
   // Pin drivers
   // ***************************************************************
   always_comb begin
      port_e_o  = e_lat_q;
      port_e_oe = ~st_reg.e_dir;
      case (mode)
         PEFG_MODE_BUS: begin
            port_e_o  = ext_addr_hi;
            port_e_oe = 8'hFF;
         end
         PEFG_MODE_SP: begin
            port_e_oe[2:0] = 3'b000;
         end
         default: begin
         end
      endcase
      if (mode != PEFG_MODE_BUS) begin
         if (st_reg.cfg[PEFG_CFG_PWMMX_BIT]) begin
            port_e_o[6:3] = pwm_out;
            port_e_oe[6:3] = 4'hF;
         end
         if (mcu_mode && !st_reg.cfg[PEFG_CFG_CH2MX_BIT] && ch2_oe) begin
            port_e_o[PEFG_PIN_CH2]  = ch2_out;
            port_e_oe[PEFG_PIN_CH2] = 1'b1;
         end
      end
   end

   assign pwm_alt_out = st_reg.cfg[PEFG_CFG_PWMMX_BIT] ? 4'h0 : pwm_out;
   assign ch2_on_alt  = !(mcu_mode && !st_reg.cfg[PEFG_CFG_CH2MX_BIT]);
   assign ch2_in      = e_sync[PEFG_PIN_CH2];

   // One disables the driver, zero drives the latch.
   assign port_f_o  = f_lat_q;
   assign port_f_oe = ~st_reg.f_dir;

   // ***************************************************************
   // Slave-port strobes
   // ***************************************************************
   logic sp_cs;
   assign sp_cs          = sp_active && !e_sync[PEFG_PIN_CS];
   assign sp_read_active = sp_cs && !e_sync[PEFG_PIN_RD];
   assign lower_data_port_in = st_reg.ldp_in;
   assign sp_wr_edge = sp_cs && !wr_n_prev_reg && e_sync[PEFG_PIN_WR];
   assign sp_rd_edge = sp_cs && !rd_n_prev_reg && e_sync[PEFG_PIN_RD];
   assign sp_write_pulse = sp_wr_edge;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rd_n_prev_reg <= 1'b1;
         wr_n_prev_reg <= 1'b1;
      end else begin
         rd_n_prev_reg <= e_sync[PEFG_PIN_RD];
         wr_n_prev_reg <= e_sync[PEFG_PIN_WR];
      end
   end

   // ***************************************************************
   // Wishbone slave and register file
   // ***************************************************************
   assign acc    = req.cyc && req.stb && !st_reg.ack;
   assign wr_acc = acc && req.we && req.sel[0];
   // Port register writes land in the latch, just like latch writes.
   assign e_lat_wr = wr_acc && (req.adr == PEFG_ADDR_E_LAT || req.adr == PEFG_ADDR_E_PINS);
   assign f_lat_wr = wr_acc && (req.adr == PEFG_ADDR_F_LAT || req.adr == PEFG_ADDR_F_PINS);

   always_comb begin
      st_next     = st_reg;
      st_next.ack = acc;
      st_next.dat = 32'h0000_0000;
      // Host write stores data; a hit while still full flags overflow.
      if (sp_wr_edge) begin
         st_next.ldp_in = lower_data_port_out;
         if (st_reg.spctl[PEFG_SP_IBF_BIT]) begin
            st_next.spctl[PEFG_SP_INPUT_BUFFER_OVERFLOW_BIT] = 1'b1;
         end
         st_next.spctl[PEFG_SP_IBF_BIT] = 1'b1;
      end
      if (sp_rd_edge) begin
         st_next.spctl[PEFG_SP_OBF_BIT] = 1'b0;
      end
      if (wr_acc) begin
         case (req.adr)
            PEFG_ADDR_E_DIR: begin
               st_next.e_dir = req.dat[7:0];
            end
            PEFG_ADDR_F_DIR: begin
               st_next.f_dir = req.dat[7:0];
            end
            PEFG_ADDR_BUSCTL: begin
               st_next.busctl = req.dat[7:0] & PEFG_BUSCTL_MASK;
            end
            PEFG_ADDR_SPCTL: begin
               st_next.spctl[PEFG_SP_MODE_BIT] = req.dat[PEFG_SP_MODE_BIT];
               // Writing zero clears overflow unless a new overflow lands in the same cycle.
               if (!req.dat[PEFG_SP_INPUT_BUFFER_OVERFLOW_BIT]
                   && !(sp_wr_edge && st_reg.spctl[PEFG_SP_IBF_BIT])) begin
                  st_next.spctl[PEFG_SP_INPUT_BUFFER_OVERFLOW_BIT] = 1'b0;
               end
            end
            PEFG_ADDR_CFG: begin
               st_next.cfg = req.dat[1:0];
            end
            PEFG_ADDR_LDP: begin
               st_next.spctl[PEFG_SP_OBF_BIT] = 1'b1;
            end
            PEFG_ADDR_F_PINS: begin
               st_next.f_por_mask = 1'b0;
            end
            default: begin
            end
         endcase
      end
      if (acc && !req.we) begin
         case (req.adr)
            PEFG_ADDR_E_DIR: begin
               st_next.dat[7:0] = st_reg.e_dir;
            end
            PEFG_ADDR_E_PINS: begin
               st_next.dat[7:0] = e_sync;
            end
            PEFG_ADDR_E_LAT: begin
               st_next.dat[7:0] = e_lat_q;
            end
            PEFG_ADDR_BUSCTL: begin
               st_next.dat[7:0] = busctl_rd;
            end
            PEFG_ADDR_SPCTL: begin
               st_next.dat[7:0] = st_reg.spctl & PEFG_SPCTL_MASK;
            end
            PEFG_ADDR_F_DIR: begin
               st_next.dat[7:0] = st_reg.f_dir;
            end
            PEFG_ADDR_F_PINS: begin
               // Pins 6:0 read zero until software writes the port F pin or latch register.
               st_next.dat[7:0] = st_reg.f_por_mask ? (f_sync & PEFG_F_PIN_PORMSK) : f_sync;
            end
            PEFG_ADDR_F_LAT: begin
               st_next.dat[7:0] = f_lat_q;
            end
            PEFG_ADDR_CFG: begin
               st_next.dat[1:0] = st_reg.cfg;
            end
            PEFG_ADDR_LDP: begin
               st_next.dat[7:0] = st_reg.ldp_in;
               if (!sp_wr_edge) begin
                  st_next.spctl[PEFG_SP_IBF_BIT] = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
      if (f_lat_wr) begin
         st_next.f_por_mask = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_reg.e_dir      <= PEFG_DIR_RST;
         st_reg.f_dir      <= PEFG_DIR_RST;
         st_reg.busctl     <= PEFG_BUSCTL_RST;
         st_reg.spctl      <= PEFG_SPCTL_RST;
         st_reg.ldp_in     <= 8'h00;
         st_reg.cfg        <= 2'b00;
         st_reg.f_por_mask <= 1'b1;
         st_reg.ack        <= 1'b0;
         st_reg.dat        <= 32'h0000_0000;
         st_reg.e_lat      <= 8'h00;
         st_reg.f_lat      <= 8'h00;
      end else begin
         st_reg <= st_next;
      end
   end

   assign wb_ack_o = st_reg.ack;
   assign wb_dat_o = st_reg.dat;

endmodule : pefg_port_ef
`default_nettype wire

/* pefg_port_ef_monitor.sv */
// Checker for the port E / port F block, bound to every pefg_port_ef instance.
// Assumes a single clk_sys domain and the asynchronous active-high rst.
`timescale 1ns/1ps
`default_nettype none
module pefg_port_ef_chk
   import pefg_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic        wb_ack_o,
   input wire logic        mcu_mode,
   input wire logic [7:0]  ext_addr_hi,
   input wire logic [7:0]  lower_data_port_out,
   input wire logic [7:0]  lower_data_port_in,
   input wire logic        sp_read_active,
   input wire logic        sp_write_pulse,
   input wire logic        port_e_ttl_sel,
   input wire logic [7:0]  port_e_o,
   input wire logic [7:0]  port_e_oe,
   input wire logic [7:0]  port_f_o,
   input wire logic [7:0]  port_f_oe
);
   // ****************
   // Properties
   // ****************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in one cycle");
   a_f_dir_oe: assert property (
      wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == PEFG_ADDR_F_DIR
      |=> port_f_oe == ~8'($past(wb_dat_i)))
      else $error("port F enables differ from written direction");
   a_f_lat_drive: assert property (
      wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == PEFG_ADDR_F_LAT
      |=> (port_f_o & port_f_oe) == (8'($past(wb_dat_i)) & port_f_oe))
      else $error("port F driven value differs from latch");
   a_e_dir_reset: assert property ($fell(rst) && mcu_mode |-> port_e_oe == 8'h00)
      else $error("port E drives a pin after reset");
   a_bus_addr: assert property (!mcu_mode && port_e_ttl_sel |-> port_e_o == ext_addr_hi)
      else $error("bus mode does not carry the high address byte");
   a_ttl_slave: assert property (sp_read_active |-> port_e_ttl_sel)
      else $error("slave read with Schmitt inputs selected");
   a_slave_mcu: assert property (sp_read_active || sp_write_pulse |-> mcu_mode)
      else $error("slave port active outside microcontroller mode");
   a_wr_single: assert property (sp_write_pulse |=> !sp_write_pulse [*3])
      else $error("write pulse repeated");
   a_wr_capture: assert property (
      sp_write_pulse |=> lower_data_port_in == $past(lower_data_port_out))
      else $error("host byte not captured");
   c_write: cover property (sp_write_pulse);
   c_read: cover property (sp_read_active);
   c_bus: cover property (!mcu_mode && port_e_ttl_sel);
endmodule : pefg_port_ef_chk
bind pefg_port_ef pefg_port_ef_chk u_chk (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
   .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .mcu_mode(mcu_mode), .ext_addr_hi(ext_addr_hi),
   .lower_data_port_out(lower_data_port_out), .lower_data_port_in(lower_data_port_in),
   .sp_read_active(sp_read_active), .sp_write_pulse(sp_write_pulse),
   .port_e_ttl_sel(port_e_ttl_sel), .port_e_o(port_e_o), .port_e_oe(port_e_oe),
   .port_f_o(port_f_o), .port_f_oe(port_f_oe));
`default_nettype wire

/* pefg_sync.sv */
// Three-stage synchroniser bank with agreement filter for pin inputs.
// Assumes inputs are asynchronous to clk_sys; output changes when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pefg_sync
   import pefg_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;

   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               s1_reg[gi]   <= 1'b1;
               s2_reg[gi]   <= 1'b1;
               s3_reg[gi]   <= 1'b1;
               sync_out[gi] <= 1'b1;
            end else begin
               s1_reg[gi] <= async_in[gi];
               s2_reg[gi] <= s1_reg[gi];
               s3_reg[gi] <= s2_reg[gi];
               if (s2_reg[gi] == s3_reg[gi]) begin
                  sync_out[gi] <= s3_reg[gi];
               end
            end
         end
      end
   endgenerate
endmodule : pefg_sync
`default_nettype wire

/* test_port_e_f_gpio_with_psp_control.sv */
// Self-checking bench for the port E / port F block with host strobes.
// Assumes pefg_pkg, pefg_port_ef, the checker and pefg_host are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_port_e_f_gpio_with_psp_control
   import pefg_pkg::*;
;
   logic        clk_sys = 1'b0, rst = 1'b1, por = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic        mcu = 1'b1, ch2_out = 1'b0, ch2_oe = 1'b0;
   logic [3:0]  sel = 4'hF, pwm = 4'h0;
   logic [7:0]  adr = 8'h00, ext = 8'h00, e_drv = 8'hFF, f_drv = 8'hFF;
   logic [7:0]  q, b, dir, lat, fd, fl, ep;
   logic [31:0] wdat = 32'h00000000;
   wire logic [31:0] rdat;
   wire logic [7:0]  ldp_in, schm, e_i, e_o, e_oe, f_i, f_o, f_oe, hdat;
   wire logic [3:0]  pwm_alt;
   wire logic [2:0]  hctl;
   wire logic        ack, ch2_in, ch2_alt, sp_rd, sp_wr, ttl;
   int          errors = 0, tests_run = 0, cycles = 0;
   // ****************
   // Clock, pins, instances
   // ****************
   always #50 clk_sys = ~clk_sys;
   assign e_i = (e_oe & e_o) | (~e_oe & {e_drv[7:3], hctl});
   assign f_i = (f_oe & f_o) | (~f_oe & f_drv);
   pefg_host u_host (.clk_sys(clk_sys), .ctl_n(hctl), .data(hdat));
   pefg_port_ef DUT (.clk_sys(clk_sys), .rst(rst), .por(por), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .mcu_mode(mcu), .ext_addr_hi(ext), .pwm_out(pwm), .ch2_out(ch2_out),
      .ch2_oe(ch2_oe), .ch2_in(ch2_in), .pwm_alt_out(pwm_alt), .ch2_on_alt(ch2_alt),
      .lower_data_port_out(hdat), .lower_data_port_in(ldp_in), .sp_read_active(sp_rd),
      .sp_write_pulse(sp_wr), .port_e_in_schmitt(schm), .port_e_ttl_sel(ttl),
      .port_e_i(e_i), .port_e_o(e_o), .port_e_oe(e_oe), .port_f_i(f_i), .port_f_o(f_o),
      .port_f_oe(f_oe));
   // ****************
   // Tasks
   // ****************
   function automatic logic [7:0] pins(input logic [7:0] d, l, p);
      return (~d & l) | (d & p);
   endfunction : pins
   task automatic end_sim;
      $display("comparisons %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h000000, d};
      do begin
         @(posedge clk_sys);
         n++;
      end while (ack !== 1'b1 && n < 40);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 40) begin
         errors++;
         end_sim();
      end
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      check(q, e);
   endtask : rd
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         end_sim();
      end
   end
   // ****************
   // Scenarios
   // ****************
   initial begin
      void'($urandom(32'h067E84E7));
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      por <= 1'b0;
      rd(PEFG_ADDR_E_DIR, 8'hFF);
      rd(PEFG_ADDR_SPCTL, 8'h00);
      repeat (6) @(posedge clk_sys);
      rd(PEFG_ADDR_F_PINS, 8'h80);
      bus(1'b1, PEFG_ADDR_CFG, 8'h02);
      // Port F is used as plain digital I/O; its analog functions are taken as off.
      for (int i = 0; i < 8; i++) begin
         dir = 8'($urandom);
         lat = 8'($urandom);
         fd = 8'($urandom);
         fl = 8'($urandom);
         e_drv <= 8'($urandom);
         f_drv <= 8'($urandom);
         bus(1'b1, PEFG_ADDR_E_DIR, dir);
         bus(1'b1, PEFG_ADDR_E_LAT, lat);
         bus(1'b1, PEFG_ADDR_F_DIR, fd);
         bus(1'b1, PEFG_ADDR_F_LAT, fl);
         rd(PEFG_ADDR_F_LAT, fl);
         rd(PEFG_ADDR_E_LAT, lat);
         check(f_oe, ~fd);
         check(f_o & ~fd, fl & ~fd);
         repeat (6) @(posedge clk_sys);
         ep = pins(dir, lat, {e_drv[7:3], 3'b111});
         rd(PEFG_ADDR_E_PINS, ep);
         check(schm, ep);
         check(ch2_in, ep[7]);
         rd(PEFG_ADDR_F_PINS, pins(fd, fl, f_drv));
      end
      bus(1'b1, PEFG_ADDR_E_PINS, 8'hC3);
      rd(PEFG_ADDR_E_LAT, 8'hC3);
      bus(1'b1, PEFG_ADDR_F_PINS, 8'h3C);
      rd(PEFG_ADDR_F_LAT, 8'h3C);
      bus(1'b1, PEFG_ADDR_BUSCTL, 8'hFF);
      rd(PEFG_ADDR_BUSCTL, 8'hB3);
      bus(1'b1, PEFG_ADDR_BUSCTL, 8'h00);
      mcu <= 1'b0;
      ext <= 8'($urandom);
      repeat (2) @(posedge clk_sys);
      check(e_o, ext);
      check(ttl, 1'b1);
      bus(1'b1, PEFG_ADDR_BUSCTL, 8'h80);
      @(posedge clk_sys);
      check(ttl, 1'b0);
      mcu <= 1'b1;
      pwm <= 4'($urandom);
      bus(1'b1, PEFG_ADDR_CFG, 8'h01);
      check(e_o[6:3], pwm);
      bus(1'b1, PEFG_ADDR_CFG, 8'h00);
      check(pwm_alt, pwm);
      check(ch2_alt, 1'b0);
      ch2_oe <= 1'b1;
      @(posedge clk_sys);
      check({e_oe[7], e_o[7]}, 2'b10);
      bus(1'b1, PEFG_ADDR_CFG, 8'h02);
      check(ch2_alt, 1'b1);
      check(e_o[7], 1'b1);
      ch2_oe <= 1'b0;
      bus(1'b1, PEFG_ADDR_E_LAT, 8'h5A);
      rst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      rd(PEFG_ADDR_E_LAT, 8'h5A);
      rd(PEFG_ADDR_E_DIR, 8'hFF);
      rd(8'h3C, 8'h00);
      bus(1'b1, PEFG_ADDR_E_LAT, 8'hFF);
      bus(1'b1, PEFG_ADDR_E_DIR, 8'h00);
      bus(1'b1, PEFG_ADDR_SPCTL, 8'h10);
      check(e_oe, 8'hF8);
      bus(1'b1, PEFG_ADDR_E_DIR, 8'hFF);
      b = 8'($urandom);
      u_host.xfer(1'b0, 1'b1, b);
      check(ldp_in, b);
      rd(PEFG_ADDR_SPCTL, 8'h90);
      u_host.xfer(1'b0, 1'b0, ~b);
      check(ldp_in, b);
      fork
         u_host.xfer(1'b1, 1'b1, 8'h00);
         begin
            repeat (10) @(posedge clk_sys);
            check(sp_rd, 1'b1);
         end
      join
      bus(1'b1, PEFG_ADDR_BUSCTL, 8'h80);
      mcu <= 1'b0;
      u_host.xfer(1'b0, 1'b1, ~b);
      check(ldp_in, b);
      end_sim();
   end
endmodule : test_port_e_f_gpio_with_psp_control
`default_nettype wire
